// [logic/ecpf_defs.svh]
// constants of the mode-selected port fifo and its configuration pair
// assumes the including file is compiled once per unit or guarded here
//
// Notes on behaviour
// - parallel-fifo mode sends fifo words by standard handshake
// - ecp forward sends queued words by ecp handshake
// - ecp reverse packs peripheral bytes into words
// - test mode never hands words to handshake
// - test mode may show head on data lines
// - test fifo never stalls; full/empty stay true
// - test fifo takes one word every clock
// - test reads return head in written order
// - service flag keeps working in test mode
// - configuration pair reachable only in configuration mode
// - config a bit 7 reports level interrupts
// - config a bits 6:4 report word width code
// - config a bit 2 reports pipeline byte accounting
// - config a bits 1:0 snapshot head bytes
// - config b readable and writable
// - config b bit 7 enables compression, default off
// - config b bit 6 mirrors interrupt line level
// - config b bits 5:3 select interrupt line
// - config b bits 2:0 select dma channel
// - standard mode holds fifo in reset, snapshot
// - hardware sets service flag; writing one also sets it
`ifndef ECPF_DEFS_SVH
`define ECPF_DEFS_SVH

// bus and word widths, register offsets
`define ECPF_ADDR_W      11
`define ECPF_WORD_W      16
`define ECPF_OFS_FIFO    11'h400
`define ECPF_OFS_CFGB    11'h401

// port mode codes
`define ECPF_MODE_STD    3'h0
`define ECPF_MODE_PS2    3'h1
`define ECPF_MODE_PFIFO  3'h2
`define ECPF_MODE_ECP    3'h3
`define ECPF_MODE_TEST   3'h6
`define ECPF_MODE_CONFIG 3'h7

// queue geometry and service thresholds in port words
`define ECPF_DEPTH       16
`define ECPF_PTR_W       4
`define ECPF_CNT_W       5
`define ECPF_DEPTH_CNT   5'h10
`define ECPF_FREE_THR    5'h08
`define ECPF_FILL_THR    5'h08

// implementation facts shown in configuration a
`define ECPF_LEVEL_IRQ   1'b1
`define ECPF_WIDTH_CODE  3'h0
`define ECPF_PIPE_BYTE   1'b1
`define ECPF_MISC_BIT    1'b0

// configuration b reset values and field positions
`define ECPF_IRQ_SEL_RST 3'h1
`define ECPF_DMA_SEL_RST 3'h5
`define ECPF_B_COMP      7
`define ECPF_B_IRQV      6
`define ECPF_B_IRQ_HI    5
`define ECPF_B_IRQ_LO    3
`define ECPF_B_DMA_HI    2
`define ECPF_B_DMA_LO    0

`endif

// [logic/ecpf_pkg.sv]
// types shared by the port fifo block
// assumes ecpf_defs.svh is on the include path
`include "ecpf_defs.svh"

package ecpf_pkg;

   // one port word as moved by the host
   typedef logic [`ECPF_WORD_W-1:0] ecpf_port_word_t;

   // one host i/o or dma cycle, valid for a single clock
   typedef struct packed {
      logic                   wr;    // write strobe
      logic                   rd;    // read strobe
      logic [`ECPF_ADDR_W-1:0] addr; // i/o offset
      ecpf_port_word_t        data;  // write data
   } ecpf_io_req_t;

   // reverse byte packer phase
   typedef enum logic {
      PACK_LOW  = 1'b0,
      PACK_HIGH = 1'b1
   } ecpf_pack_t;

endpackage

// [logic/ecpf_queue.sv]
// circular word store with optional overwrite for the port fifo
// assumes one clock; flush and push/pop come from the same domain
`timescale 1ns/1ps
`include "ecpf_defs.svh"

module ecpf_queue
   import ecpf_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   flush,
   input  wire logic                   push,
   input  wire logic                   pop,
   input  wire logic                   overwrite,
   input  wire ecpf_port_word_t        wrData,
   output ecpf_port_word_t             head,
   output ecpf_port_word_t             headNext,
   output logic [`ECPF_CNT_W-1:0]      count,
   output logic [`ECPF_CNT_W-1:0]      nextCount
);

   ecpf_port_word_t         mem [`ECPF_DEPTH]; // word storage
   logic [`ECPF_PTR_W-1:0]  wrPtr;             // next slot to fill
   logic [`ECPF_PTR_W-1:0]  rdPtr;             // head slot
   logic [`ECPF_PTR_W-1:0]  next_wrPtr;
   logic [`ECPF_PTR_W-1:0]  next_rdPtr;
   logic                    isFull;            // every slot used
   logic                    accept;            // push really stored
   logic                    doPop;             // pop really taken
   logic                    dropOld;           // oldest word overwritten

   // decide what this edge does to the pointers
   always_comb begin
      isFull  = (count == `ECPF_DEPTH_CNT);
      accept  = push && !flush && (!isFull || overwrite);
      doPop   = pop && !flush && (count != '0);
      dropOld = accept && isFull && !doPop;
      next_wrPtr = accept ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = (doPop || dropOld) ? rdPtr + 1'b1 : rdPtr;
      nextCount  = count;
      if (flush) begin
         next_wrPtr = '0;
         next_rdPtr = '0;
         nextCount  = '0;
      end else if (accept && !doPop && !dropOld) begin
         nextCount = count + 1'b1;
      end else if (doPop && !accept) begin
         nextCount = count - 1'b1;
      end
      // forward a word landing on the slot that becomes the head
      headNext = (accept && wrPtr == next_rdPtr) ? wrData
                                                 : mem[next_rdPtr];
      head     = mem[rdPtr];
   end

   // pointer and occupancy state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= nextCount;
      end
   end

   // storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (accept) begin
         mem[wrPtr] <= wrData;
      end
   end

endmodule

// [logic/ecpf_port_fifo.sv]
// mode-selected fifo and configuration registers of the parallel port
// assumes mode, direction, dma and service writes come from the
// extended control logic on this clock; the handshake machines use
// txWord/txValid/txTake and rxByte/rxStrobe/rxReady; the interrupt
// request pin is asynchronous and synchronised here
`timescale 1ns/1ps
`include "ecpf_defs.svh"

module ecpf_port_fifo
   import ecpf_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire ecpf_io_req_t           ioReq,
   output ecpf_port_word_t             ioRdData,
   output logic                        ioRdValid,
   input  wire logic [2:0]             portMode,
   input  wire logic                   direction,
   input  wire logic                   dmaEn,
   input  wire logic                   dmaTermCount,
   input  wire logic                   svcWrite,
   input  wire logic                   svcWriteValue,
   output logic                        serviceRequestFlag,
   output logic                        fifoFull,
   output logic                        fifoEmpty,
   output ecpf_port_word_t             txWord,
   output logic                        txValid,
   input  wire logic                   txTake,
   input  wire logic [7:0]             rxByte,
   input  wire logic                   rxStrobe,
   output logic                        rxReady,
   input  wire logic [1:0]             headBytesLeft,
   input  wire logic                   irqLinePin,
   output logic [7:0]                  testLineData,
   output logic                        compressEn,
   output logic [2:0]                  irqSelect,
   output logic [2:0]                  dmaChannelSelect
);

   // mode decode
   logic                   isStdLike;    // fifo held in reset
   logic                   isPfifo;      // standard fifo mode
   logic                   isEcpFwd;     // ecp forward
   logic                   isEcpRev;     // ecp reverse
   logic                   isTest;       // loop-back test mode
   logic                   isConfig;     // configuration mode
   logic                   fifoSel;      // access hits fifo offset
   logic                   cfgBSel;      // access hits second offset

   // queue handshake
   logic                   hostPush;     // host write into fifo
   logic                   hostPop;      // host read out of fifo
   logic                   txPop;        // handshake consumed head
   logic                   rxPush;       // packed word ready
   logic                   qPush;
   logic                   qPop;
   ecpf_port_word_t        qWrData;
   ecpf_port_word_t        qHead;
   ecpf_port_word_t        qHeadNext;
   logic [`ECPF_CNT_W-1:0] qCount;
   logic [`ECPF_CNT_W-1:0] qNextCount;
   logic [`ECPF_CNT_W-1:0] freeWords;    // unused slots

   // reverse packing
   ecpf_pack_t             packPhase;    // which byte comes next
   logic [7:0]             lowByte;      // first byte of a word

   // service and configuration state
   logic                   svcCond;      // a service condition holds
   logic [2:0]             prevMode;     // mode one clock ago
   logic [1:0]             headSnap;     // host recovery snapshot
   logic                   irqMeta;      // first sync stage
   logic                   irqLineLevel; // synchronised line level

   // true when a mode feeds the handshake from the fifo
   function automatic logic drains(input logic [2:0] m,
                                   input logic       dir);
      drains = (m == `ECPF_MODE_PFIFO) ||
               (m == `ECPF_MODE_ECP && !dir);
   endfunction

   // decode mode and offsets
   always_comb begin
      isStdLike = (portMode == `ECPF_MODE_STD) ||
                  (portMode == `ECPF_MODE_PS2);
      isPfifo   = (portMode == `ECPF_MODE_PFIFO);
      isEcpFwd  = (portMode == `ECPF_MODE_ECP) && !direction;
      isEcpRev  = (portMode == `ECPF_MODE_ECP) && direction;
      isTest    = (portMode == `ECPF_MODE_TEST);
      isConfig  = (portMode == `ECPF_MODE_CONFIG);
      fifoSel   = (ioReq.addr == `ECPF_OFS_FIFO) && !isConfig;
      cfgBSel   = (ioReq.addr == `ECPF_OFS_CFGB);
   end

   // steer host, handshake and packer onto the one queue
   always_comb begin
      // host writes only where the fifo faces outward or in test
      hostPush = ioReq.wr && fifoSel &&
                 (isPfifo || isEcpFwd || isTest);
      // host reads in reverse ecp, or any direction in test
      hostPop  = ioReq.rd && fifoSel && (isEcpRev || isTest);
      txPop    = txTake && txValid && drains(portMode, direction);
      rxPush   = rxStrobe && isEcpRev && (packPhase == PACK_HIGH);
      qPush    = hostPush || rxPush;
      qPop     = hostPop || txPop;
      qWrData  = rxPush ? {rxByte, lowByte} : ioReq.data;
      freeWords = `ECPF_DEPTH_CNT - qCount;
   end

   // word store; test mode overwrites instead of stalling
   ecpf_queue u_queue (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .flush     (isStdLike),
      .push      (qPush),
      .pop       (qPop),
      .overwrite (isTest),
      .wrData    (qWrData),
      .head      (qHead),
      .headNext  (qHeadNext),
      .count     (qCount),
      .nextCount (qNextCount)
   );

   // occupancy flags follow the count of the coming cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fifoFull  <= 1'b0;
         fifoEmpty <= 1'b1;
      end else begin
         fifoFull  <= (qNextCount == `ECPF_DEPTH_CNT);
         fifoEmpty <= (qNextCount == '0);
      end
   end

   // head word offered to the outgoing handshake
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txValid <= 1'b0;
         txWord  <= '0;
      end else begin
         // never offered in test mode
         txValid <= drains(portMode, direction) &&
                    (qNextCount != '0);
         txWord  <= qHeadNext;
      end
   end

   // test mode shows the head's low byte with no handshake
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         testLineData <= 8'h00;
      end else if (isTest) begin
         testLineData <= qHeadNext[7:0];
      end else begin
         testLineData <= 8'h00;
      end
   end

   // pack reverse bytes low first; flushed with the fifo
   always_ff @(posedge clk) begin
      if (sys_rst || isStdLike) begin
         packPhase <= PACK_LOW;
         lowByte   <= 8'h00;
      end else if (rxStrobe && isEcpRev) begin
         // second byte completes the word
         if (packPhase == PACK_LOW) begin
            lowByte   <= rxByte;
            packPhase <= PACK_HIGH;
         end else begin
            packPhase <= PACK_LOW;
         end
      end
   end

   // reverse handshake may hand a byte only while room remains
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxReady <= 1'b0;
      end else begin
         rxReady <= isEcpRev && (qNextCount != `ECPF_DEPTH_CNT);
      end
   end

   // service condition: dma terminal count or threshold reached
   always_comb begin
      svcCond = 1'b0;
      if (!isStdLike && !isConfig) begin
         if (dmaEn) begin
            svcCond = dmaTermCount;
         end else if (!direction) begin
            svcCond = (freeWords >= `ECPF_FREE_THR);
         end else begin
            svcCond = (qCount >= `ECPF_FILL_THR);
         end
      end
   end

   // service flag; a condition in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serviceRequestFlag <= 1'b1;
      end else if (svcCond) begin
         serviceRequestFlag <= 1'b1;
      end else if (svcWrite) begin
         // writing one sets the flag, writing zero clears it
         serviceRequestFlag <= svcWriteValue;
      end
   end

   // remember mode for the host recovery snapshot
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prevMode <= `ECPF_MODE_STD;
         headSnap <= 2'h0;
      end else begin
         prevMode <= portMode;
         // leaving ecp resets the fifo: catch head byte count
         if (prevMode == `ECPF_MODE_ECP && isStdLike) begin
            headSnap <= headBytesLeft;
         end
      end
   end

   // two-stage sync of the interrupt request pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqMeta      <= 1'b0;
         irqLineLevel <= 1'b0;
      end else begin
         irqMeta      <= irqLinePin;
         irqLineLevel <= irqMeta;
      end
   end

   // routing and compression fields, written in config mode only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         compressEn       <= 1'b0;
         irqSelect        <= `ECPF_IRQ_SEL_RST;
         dmaChannelSelect <= `ECPF_DMA_SEL_RST;
      end else if (ioReq.wr && cfgBSel && isConfig) begin
         compressEn <= ioReq.data[`ECPF_B_COMP];
         irqSelect  <=
            ioReq.data[`ECPF_B_IRQ_HI:`ECPF_B_IRQ_LO];
         dmaChannelSelect <=
            ioReq.data[`ECPF_B_DMA_HI:`ECPF_B_DMA_LO];
      end
   end

   // read answer for the two offsets this block owns
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ioRdData  <= '0;
         ioRdValid <= 1'b0;
      end else begin
         ioRdValid <= ioReq.rd &&
                      (ioReq.addr == `ECPF_OFS_FIFO || cfgBSel);
         ioRdData  <= '0;
         if (ioReq.rd && ioReq.addr == `ECPF_OFS_FIFO) begin
            if (isConfig) begin
               // implementation facts and snapshot
               ioRdData <= {8'h00, `ECPF_LEVEL_IRQ,
                            `ECPF_WIDTH_CODE,
                            `ECPF_MISC_BIT,
                            `ECPF_PIPE_BYTE,
                            headSnap};
            end else if (isEcpRev || isTest) begin
               // head word; underrun in test rereads it
               ioRdData <= qHead;
            end
         end else if (ioReq.rd && cfgBSel && isConfig) begin
            ioRdData <= {8'h00, compressEn,
                         irqLineLevel,
                         irqSelect, dmaChannelSelect};
         end
      end
   end

   // ---- checks ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // a test write while full then the flags next cycle
   sequence s_test_full_wr;
      isTest && hostPush && qCount == `ECPF_DEPTH_CNT && !hostPop;
   endsequence

   // ecp run followed by return to a standard mode
   sequence s_leave_ecp;
      portMode == `ECPF_MODE_ECP ##1 isStdLike;
   endsequence

   a_flush_empties: assert property (
      isStdLike |=> fifoEmpty && qCount == '0 && !txValid)
      else $error("fifo not held empty in standard mode");

   a_full_tracks: assert property (
      fifoFull == (qCount == `ECPF_DEPTH_CNT) &&
      fifoEmpty == (qCount == '0))
      else $error("full or empty disagrees with occupancy");

   a_test_nostall: assert property (
      s_test_full_wr |=> fifoFull ##0 qHead == $past(qHeadNext))
      else $error("test fifo stalled or lost overwrite");

   a_test_rate: assert property (
      isTest && hostPush && !hostPop && qCount < `ECPF_DEPTH_CNT
      |=> qCount == $past(qCount) + 5'h01)
      else $error("test write not taken in one clock");

   a_test_order: assert property (
      isTest && hostPop && qCount != '0
      |=> ioRdData == $past(qHead) ##0 ioRdValid)
      else $error("test read did not return head word");

   a_test_notx: assert property (
      isTest [*2] |-> !txValid)
      else $error("test mode offered data to handshake");

   a_pfifo_tx: assert property (
      isPfifo && qNextCount != '0 |=> txValid ##0 txWord == qHead)
      else $error("parallel fifo word not offered");

   a_rx_pack: assert property (
      isEcpRev && rxStrobe && packPhase == PACK_HIGH && !hostPop &&
      qCount < `ECPF_DEPTH_CNT |=> qCount == $past(qCount) + 5'h01)
      else $error("second reverse byte did not push a word");

   a_svc_sets: assert property (
      svcCond |=> serviceRequestFlag [*1])
      else $error("service flag not set by condition");

   a_svc_holds: assert property (
      serviceRequestFlag && !(svcWrite && !svcWriteValue)
      |=> serviceRequestFlag)
      else $error("service flag dropped without a clear");

   a_cfg_hidden: assert property (
      ioReq.rd && cfgBSel && !isConfig |=> ioRdData == '0)
      else $error("config b visible outside config mode");

   a_snapshot: assert property (
      s_leave_ecp |=> headSnap == $past(headBytesLeft))
      else $error("host recovery snapshot not captured");

   a_irq_mirror: assert property (
      ioReq.rd && cfgBSel && isConfig
      |=> ioRdData[`ECPF_B_IRQV] == $past(irqLineLevel))
      else $error("config b line level not mirrored");

endmodule

// [bench/ecpf_peer_model.sv]
// handshake machines beside the port fifo: forward taker, reverse sender
// assumes the fifo clock; the bench fills rxq and reads got
`timescale 1ns/1ps

module ecpf_peer_model
   import ecpf_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            slow,
   input  wire ecpf_port_word_t txWord,
   input  wire logic            txValid,
   output logic                 txTake,
   output logic [7:0]           rxByte,
   output logic                 rxStrobe,
   input  wire logic            rxReady
);
   ecpf_port_word_t got[$];  // words taken forward
   logic [7:0]      rxq[$];  // bytes waiting to go in reverse

   initial begin
      txTake = 1'b0;
      rxByte = 8'h00;
      rxStrobe = 1'b0;
   end

   // forward taker, every cycle or every other when slow
   always @(posedge clk) begin
      if (txTake && txValid) begin
         got.push_back(txWord);
      end
      txTake <= txValid && !(slow && txTake);
   end

   // reverse sender, strobes only while ready; idle data keeps toggling
   always @(posedge clk) begin
      if (rxq.size() > 0 && rxReady && !rxStrobe) begin
         rxByte   <= rxq.pop_front();
         rxStrobe <= 1'b1;
      end else begin
         rxByte   <= ~rxByte;
         rxStrobe <= 1'b0;
      end
   end
endmodule

// [bench/ecpf_port_fifo_config_tb.sv]
// self-checking bench for the port fifo and its configuration pair
// assumes ecpf_defs.svh on the include path and the peer model beside
`timescale 1ns/1ps
`include "ecpf_defs.svh"

module ecpf_port_fifo_config_tb
   import ecpf_pkg::*;
;
   logic            clk, sysRst, ioRdValid, direction, dmaEn, dmaTermCount;
   logic            svcWrite, svcWriteValue, flag, fifoFull, fifoEmpty;
   logic            txValid, txTake, rxStrobe, rxReady, irqLinePin, slow;
   logic            compressEn;
   ecpf_io_req_t    ioReq;
   ecpf_port_word_t ioRdData, txWord;
   logic [2:0]      portMode, irqSelect, dmaChannelSelect;
   logic [7:0]      rxByte, testLineData;
   logic [1:0]      headBytesLeft;
   int              failCount, totalChecks;

   ecpf_port_fifo dut_u (.clk(clk), .sys_rst(sysRst), .ioReq(ioReq),
      .ioRdData(ioRdData), .ioRdValid(ioRdValid), .portMode(portMode),
      .direction(direction), .dmaEn(dmaEn), .dmaTermCount(dmaTermCount),
      .svcWrite(svcWrite), .svcWriteValue(svcWriteValue),
      .serviceRequestFlag(flag), .fifoFull(fifoFull),
      .fifoEmpty(fifoEmpty), .txWord(txWord), .txValid(txValid),
      .txTake(txTake), .rxByte(rxByte), .rxStrobe(rxStrobe),
      .rxReady(rxReady), .headBytesLeft(headBytesLeft),
      .irqLinePin(irqLinePin), .testLineData(testLineData),
      .compressEn(compressEn), .irqSelect(irqSelect),
      .dmaChannelSelect(dmaChannelSelect));

   ecpf_peer_model peer_u (.clk(clk), .slow(slow), .txWord(txWord),
      .txValid(txValid), .txTake(txTake), .rxByte(rxByte),
      .rxStrobe(rxStrobe), .rxReady(rxReady));

   // clock of 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // wait edges, then sample just after the last one
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // back-to-back whole-word writes, one per clock
   task automatic burst(input logic [10:0] a, input int n,
                        input logic [15:0] base);
      @(posedge clk);
      ioReq.wr   <= 1'b1;
      ioReq.addr <= a;
      for (int i = 0; i < n; i++) begin
         ioReq.data <= base + 16'(i);
         @(posedge clk);
      end
      ioReq.wr <= 1'b0;
   endtask

   // one read, answer compared under a mask
   task automatic rd_check(input logic [10:0] a, input logic [15:0] m,
                           input logic [15:0] exp);
      @(posedge clk);
      ioReq.rd   <= 1'b1;
      ioReq.addr <= a;
      @(posedge clk);
      ioReq.rd <= 1'b0;
      #1;
      check(16'(ioRdValid), 16'h0001);
      check(ioRdData & m, exp);
   endtask

   // mode change always passes through the ps2 mode
   task automatic set_mode(input logic [2:0] m, input logic d);
      @(posedge clk);
      portMode  <= `ECPF_MODE_PS2;
      direction <= d;
      @(posedge clk);
      portMode <= m;
      tick(2);
   endtask

   task automatic t_config;
      set_mode(`ECPF_MODE_CONFIG, 1'b0);
      rd_check(`ECPF_OFS_FIFO, 16'hfffc, 16'h0084);
      rd_check(`ECPF_OFS_CFGB, 16'hffff, 16'h004d);
      for (int i = 1; i < 8; i++) begin
         burst(`ECPF_OFS_CFGB, 1, 16'({i[0], 1'b0, 3'(i), 3'(i)}));
         rd_check(`ECPF_OFS_CFGB, 16'hffff,
                  16'({i[0], 1'b1, 3'(i), 3'(i)}));
         check(16'({compressEn, irqSelect, dmaChannelSelect}),
               16'({i[0], 3'(i), 3'(i)}));
      end
      // drop the request pin, mirror must follow after the sync
      @(posedge clk);
      irqLinePin <= 1'b0;
      tick(2);
      rd_check(`ECPF_OFS_CFGB, 16'hffff, 16'h00bf);
      @(posedge clk);
      irqLinePin <= 1'b1;
      $display("config test done");
   endtask

   task automatic t_forward;
      peer_u.got.delete();
      set_mode(`ECPF_MODE_PFIFO, 1'b0);
      burst(`ECPF_OFS_FIFO, 3, 16'ha000);
      rd_check(`ECPF_OFS_CFGB, 16'hffff, 16'h0000);
      tick(8);
      slow <= 1'b1;
      set_mode(`ECPF_MODE_ECP, 1'b0);
      burst(`ECPF_OFS_FIFO, 2, 16'hb000);
      tick(12);
      check(16'(peer_u.got.size()), 16'h0005);
      for (int i = 0; i < 5; i++) begin
         check(peer_u.got[i], (i < 3) ? 16'ha000 + 16'(i)
                                      : 16'hb000 + 16'(i - 3));
      end
      slow <= 1'b0;
      $display("forward test done");
   endtask

   task automatic t_test;
      peer_u.got.delete();
      set_mode(`ECPF_MODE_TEST, 1'b0);
      burst(`ECPF_OFS_FIFO, 1, 16'h4433);
      burst(`ECPF_OFS_FIFO, 1, 16'h2211);
      burst(`ECPF_OFS_FIFO, 1, 16'h00ff);
      tick(3);
      check(16'(testLineData), 16'h0033);
      check(16'(txValid), 16'h0000);
      check(16'(peer_u.got.size()), 16'h0000);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'h4433);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'h2211);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'h00ff);
      check(16'(fifoEmpty), 16'h0001);
      burst(`ECPF_OFS_FIFO, 17, 16'hc000);
      tick(1);
      check(16'(fifoFull), 16'h0001);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'hc001);
      check(16'(fifoFull), 16'h0000);
      set_mode(`ECPF_MODE_STD, 1'b0);
      check(16'(fifoEmpty), 16'h0001);
      $display("test fifo test done");
   endtask

   task automatic t_service;
      set_mode(`ECPF_MODE_TEST, 1'b1);
      @(posedge clk);
      svcWrite      <= 1'b1;
      svcWriteValue <= 1'b0;
      @(posedge clk);
      svcWrite <= 1'b0;
      tick(2);
      check(16'(flag), 16'h0000);
      burst(`ECPF_OFS_FIFO, 7, 16'h0100);
      tick(2);
      check(16'(flag), 16'h0000);
      burst(`ECPF_OFS_FIFO, 1, 16'h0107);
      tick(2);
      check(16'(flag), 16'h0001);
      // dma terminal count alone drives the flag; set beats clear
      @(posedge clk);
      dmaEn    <= 1'b1;
      svcWrite <= 1'b1;
      @(posedge clk);
      svcWrite <= 1'b0;
      tick(2);
      check(16'(flag), 16'h0000);
      @(posedge clk);
      dmaTermCount <= 1'b1;
      svcWrite     <= 1'b1;
      @(posedge clk);
      dmaEn        <= 1'b0;
      dmaTermCount <= 1'b0;
      svcWrite     <= 1'b0;
      #1;
      check(16'(flag), 16'h0001);
      $display("service test done");
   endtask

   task automatic t_reverse;
      set_mode(`ECPF_MODE_ECP, 1'b1);
      peer_u.rxq = '{8'h11, 8'h22, 8'h33, 8'h44};
      tick(12);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'h2211);
      rd_check(`ECPF_OFS_FIFO, 16'hffff, 16'h4433);
      check(16'(fifoEmpty), 16'h0001);
      @(posedge clk);
      headBytesLeft <= 2'b10;
      set_mode(`ECPF_MODE_ECP, 1'b0);
      set_mode(`ECPF_MODE_CONFIG, 1'b0);
      rd_check(`ECPF_OFS_FIFO, 16'h0003, 16'h0002);
      $display("reverse and snapshot test done");
   endtask

   // watchdog, far beyond the couple of hundred cycles the tests take
   initial begin
      #(20000 * 100);
      failCount++;
      stop_test();
   end

   initial begin
      failCount = 0;
      totalChecks = 0;
      ioReq = '0;
      portMode = `ECPF_MODE_STD;
      {direction, dmaEn, dmaTermCount, svcWrite, svcWriteValue} = '0;
      headBytesLeft = 2'b00;
      irqLinePin = 1'b1;
      slow = 1'b0;
      sysRst = 1'b1;
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      t_config();
      t_forward();
      t_test();
      t_service();
      t_reverse();
      stop_test();
   end
endmodule
